// [design/lmi_pkg.sv]
// constants and shared types for the local dram memory interface
// Behaviour
// - row strobe starts every chip cycle; row latched, sensed and restored
// - read: column strobe latches column address and holds selected bit out
// - write: row step, then write line, then column strobe with input bit
// - refresh is the row strobe step only, no column strobe
// - 18-bit physical address is captured when the request is taken
// - top three address bits pick one of eight slots, fixed by position
// - each slot decodes one contiguous 32K-word window, in slot order
// - bit 0 picks chip block, bits 1-7 row, bits 8-14 column
// - data path is 21 bits: 16 data plus 5 code or 2 parity
// - 8K modules use small chips, 32K use large; only 32K carries code
// - fixed priority: refresh first, then DMA, then CPU
// - module timing runs on its own, unrelated to the processor clock
// - idle memory starts at once; busy memory queues by priority
// - address-ready returned once slot selected and address latched
// - store: data-ready comes with address-ready and ends the store
// - read: data-ready after access; parity or code check per 21-bit line (data-ready here stays low on reads)
// - memory-data-ready marks read data, then reset-data releases it
// - free-running oscillator issues periodic refresh requests
// - refresh starts only when idle, drives row counter with start strobe
// - refresh row counter is circular, advancing once per refresh request
package lmi_pkg;
   localparam int ADDR_W = 18;
   localparam int SLOT_W = 3;
   localparam int SLOTS = 8;
   localparam int ROW_W = 7;
   localparam int DATA_W = 16;
   localparam int CODE_W = 5;
   localparam int MEM_W = 21;
   localparam int BLK_BIT = 0;
   localparam int ROW_LO = 1;
   localparam int COL_LO = 8;
   localparam int SLOT_LO = 15;
   localparam logic [17:0] SLOT_SPAN = 18'h08000;
   localparam int PAR_HI_BIT = 20;
   localparam int PAR_LO_BIT = 16;
   localparam int SYNC_N = 4;
   localparam int CLK_NS = 25;
   localparam int T_RAS_NS = 120;
   localparam int T_WEN_NS = 25;
   localparam int T_CAS_NS = 60;
   localparam int T_PRE_NS = 100;
   localparam int REF_PERIOD_NS = 15600;
   localparam int T_RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WEN_CYC = (T_WEN_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_PRE_CYC = (T_PRE_NS + CLK_NS - 1) / CLK_NS;
   localparam int REF_PERIOD_CYC = REF_PERIOD_NS / CLK_NS;
   localparam int TMR_W = 4;
   localparam int REF_W = 12;
   localparam int BUF_W = DATA_W + CODE_W + 3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ROW = 3'h1,
      ST_WEN = 3'h3,
      ST_COL = 3'h2,
      ST_DATA = 3'h6,
      ST_PRE = 3'h4
   } lmi_state_t;
endpackage : lmi_pkg

// [design/lmi_buf.sv]
// two-entry read data buffer with valid and ready on both sides
`timescale 1ns/1ps
module lmi_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : lmi_buf

// [design/lmi_top.sv]
// local memory interface: arbiter, refresh, dram strobe sequencer
`timescale 1ns/1ps
module lmi_top import lmi_pkg::*; #(
   parameter int REF_CYC = REF_PERIOD_CYC,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu requester, asynchronous
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic [DATA_W-1:0] cpu_wdata,
   output logic cpu_addr_rdy,
   output logic cpu_data_rdy,
   // dma requester, asynchronous
   input wire logic dma_req,
   input wire logic dma_write,
   input wire logic [ADDR_W-1:0] dma_addr,
   input wire logic [DATA_W-1:0] dma_wdata,
   output logic dma_addr_rdy,
   output logic dma_data_rdy,
   // check code for stores, from the correction network
   input wire logic [CODE_W-1:0] wr_code,
   // read data stream toward the processor
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic [CODE_W-1:0] rd_code,
   output logic rd_dma,
   output logic rd_mod21,
   output logic rd_par_err,
   output logic reset_data,
   // memory modules
   input wire logic [SLOTS-1:0] mod21,
   output logic [SLOTS-1:0] dram_ras_n,
   output logic dram_cas_n,
   output logic dram_we_n,
   output logic dram_blk,
   output logic [ROW_W-1:0] dram_ma,
   output logic [MEM_W-1:0] dram_dq_out,
   output logic dram_dq_oe,
   input wire logic [MEM_W-1:0] dram_dq_in,
   // status
   output logic mem_busy,
   output logic ref_start
);
   // three-stage synchronisers for the asynchronous request lines
   wire [SYNC_N-1:0] raw = {dma_write, dma_req, cpu_write, cpu_req};
   logic [SYNC_N-1:0] s1_q;
   logic [SYNC_N-1:0] s2_q;
   logic [SYNC_N-1:0] s3_q;
   logic [SYNC_N-1:0] f_q;
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               f_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               // a change counts once stages two and three agree
               if (s2_q[gi] == s3_q[gi]) begin
                  f_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate
   wire cpu_req_f = f_q[0];
   wire cpu_wr_f = f_q[1];
   wire dma_req_f = f_q[2];
   wire dma_wr_f = f_q[3];

   // state
   lmi_state_t st_q;
   lmi_state_t st_d;
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] tmr_d;
   logic [REF_W-1:0] osc_q;
   logic ref_pend_q;
   logic [ROW_W-1:0] row_cnt_q;
   logic ref_q;
   logic own_dma_q;
   logic wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [CODE_W-1:0] code_q;
   logic cpu_ar_q;
   logic cpu_dr_q;
   logic dma_ar_q;
   logic dma_dr_q;

   // refresh oscillator, free running
   wire osc_tick = (osc_q == REF_W'(REF_CYC - 1));
   // requests already answered wait for the requester to drop them
   wire cpu_pend = cpu_req_f && !cpu_ar_q;
   wire dma_pend = dma_req_f && !dma_ar_q;
   wire idle = (st_q == ST_IDLE);
   wire tmr_done = (tmr_q == '0);
   wire buf_in_ready;
   // reads start only with room in the buffer, so a push is never refused
   wire dma_go = dma_pend && (dma_wr_f || buf_in_ready);
   wire cpu_go = cpu_pend && (cpu_wr_f || buf_in_ready);
   wire gnt_ref = idle && ref_pend_q;
   wire gnt_dma = idle && !ref_pend_q && dma_go;
   wire gnt_cpu = idle && !ref_pend_q && !dma_go && cpu_go;
   wire gnt_any = gnt_ref || gnt_dma || gnt_cpu;
   wire row_end = (st_q == ST_ROW) && tmr_done;
   wire ar_set = row_end && !ref_q;

   // address decode
   wire [SLOT_W-1:0] slot = addr_q[SLOT_LO +: SLOT_W];
   wire [SLOTS-1:0] slot_hot = SLOTS'(1) << slot;
   wire [ROW_W-1:0] row_a = addr_q[ROW_LO +: ROW_W];
   wire [ROW_W-1:0] col_a = addr_q[COL_LO +: ROW_W];
   wire ras_on = (st_q == ST_ROW) || (st_q == ST_WEN) ||
                 (st_q == ST_COL) || (st_q == ST_DATA);
   wire col_phase = (st_q == ST_WEN) || (st_q == ST_COL) ||
                    (st_q == ST_DATA);
   wire [SLOTS-1:0] ras_sel = ref_q ? '1 : slot_hot;
   wire sel_mod21 = mod21[slot];

   // sequencer next state
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_done ? '0 : tmr_q - 1'b1;
      unique case (st_q)
         ST_IDLE: begin
            if (gnt_any) begin
               st_d = ST_ROW;
               tmr_d = TMR_W'(T_RAS_CYC - 1);
            end
         end
         ST_ROW: begin
            if (tmr_done) begin
               if (ref_q) begin
                  st_d = ST_PRE;
                  tmr_d = TMR_W'(T_PRE_CYC - 1);
               end else if (wr_q) begin
                  st_d = ST_WEN;
                  tmr_d = TMR_W'(T_WEN_CYC - 1);
               end else begin
                  st_d = ST_COL;
                  tmr_d = TMR_W'(T_CAS_CYC - 1);
               end
            end
         end
         ST_WEN: begin
            if (tmr_done) begin
               st_d = ST_COL;
               tmr_d = TMR_W'(T_CAS_CYC - 1);
            end
         end
         ST_COL: begin
            if (tmr_done) begin
               st_d = wr_q ? ST_PRE : ST_DATA;
               tmr_d = wr_q ? TMR_W'(T_PRE_CYC - 1) : '0;
            end
         end
         ST_DATA: begin
            st_d = ST_PRE;
            tmr_d = TMR_W'(T_PRE_CYC - 1);
         end
         ST_PRE: begin
            if (tmr_done) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
            tmr_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
         tmr_q <= '0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
      end
   end

   // refresh request and circular row counter
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_q <= '0;
         ref_pend_q <= 1'b0;
         row_cnt_q <= '0;
      end else begin
         osc_q <= osc_tick ? '0 : osc_q + 1'b1;
         if (osc_tick) begin
            ref_pend_q <= 1'b1;
            row_cnt_q <= row_cnt_q + 1'b1;
         end else if (gnt_ref) begin
            ref_pend_q <= 1'b0;
         end
      end
   end

   // capture of the granted request
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_q <= 1'b0;
         own_dma_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         code_q <= '0;
      end else if (gnt_any) begin
         ref_q <= gnt_ref;
         own_dma_q <= gnt_dma;
         wr_q <= gnt_ref ? 1'b0 : (gnt_dma ? dma_wr_f : cpu_wr_f);
         addr_q <= gnt_ref ? ADDR_W'({row_cnt_q, 1'b0}) :
                   (gnt_dma ? dma_addr : cpu_addr);
         wdata_q <= gnt_dma ? dma_wdata : cpu_wdata;
         code_q <= wr_code;
      end
   end

   // address-ready and store data-ready, held until the request drops
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_ar_q <= 1'b0;
         cpu_dr_q <= 1'b0;
         dma_ar_q <= 1'b0;
         dma_dr_q <= 1'b0;
      end else begin
         if (ar_set && !own_dma_q) begin
            cpu_ar_q <= 1'b1;
            cpu_dr_q <= wr_q;
         end else if (!cpu_req_f) begin
            cpu_ar_q <= 1'b0;
            cpu_dr_q <= 1'b0;
         end
         if (ar_set && own_dma_q) begin
            dma_ar_q <= 1'b1;
            dma_dr_q <= wr_q;
         end else if (!dma_req_f) begin
            dma_ar_q <= 1'b0;
            dma_dr_q <= 1'b0;
         end
      end
   end
   assign cpu_addr_rdy = cpu_ar_q;
   assign cpu_data_rdy = cpu_dr_q;
   assign dma_addr_rdy = dma_ar_q;
   assign dma_data_rdy = dma_dr_q;

   // dram pins; strobes decode from the registered state
   assign dram_ras_n = ras_on ? ~ras_sel : '1;
   assign dram_cas_n = !((st_q == ST_COL) || (st_q == ST_DATA));
   assign dram_we_n = !(wr_q && ((st_q == ST_WEN) || (st_q == ST_COL)));
   assign dram_blk = addr_q[BLK_BIT];
   assign dram_ma = col_phase ? col_a : row_a;
   assign mem_busy = !idle;
   assign ref_start = (st_q == ST_ROW) && ref_q;
   // odd parity per byte; code bits go only to 21-bit modules
   wire par_hi = ~^wdata_q[15:8];
   wire par_lo = ~^wdata_q[7:0];
   wire [MEM_W-1:0] wr_word = sel_mod21 ? {code_q, wdata_q} :
      {par_hi, 3'h0, par_lo, wdata_q};
   assign dram_dq_out = wr_word;
   assign dram_dq_oe = wr_q && col_phase;

   // read capture and check selection
   wire rd_push = (st_q == ST_DATA);
   wire [DATA_W-1:0] q_data = dram_dq_in[DATA_W-1:0];
   wire perr = !(^{q_data[15:8], dram_dq_in[PAR_HI_BIT]}) ||
               !(^{q_data[7:0], dram_dq_in[PAR_LO_BIT]});
   // the code check itself lives in the correction network downstream
   wire [BUF_W-1:0] buf_in = {sel_mod21 ? 1'b0 : perr, sel_mod21,
      own_dma_q, dram_dq_in[MEM_W-1:DATA_W], q_data};
   wire [BUF_W-1:0] buf_out;
   lmi_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(rd_push),
      .in_ready(buf_in_ready),
      .in_data(buf_in),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(buf_out)
   );
   assign rd_data = buf_out[DATA_W-1:0];
   assign rd_code = buf_out[DATA_W +: CODE_W];
   assign rd_dma = buf_out[BUF_W-3];
   assign rd_mod21 = buf_out[BUF_W-2];
   assign rd_par_err = buf_out[BUF_W-1];
   assign reset_data = rd_valid && rd_ready;

   // checks
   property p_ras_first;
      @(posedge clk) disable iff (rst)
      $rose(dram_ras_n != '1) |-> dram_cas_n && dram_we_n;
   endproperty
   a_ras_first: assert property (p_ras_first)
      else $error("column strobe or write before row strobe");
   property p_cas_in_ras;
      @(posedge clk) disable iff (rst)
      !dram_cas_n |-> (dram_ras_n != '1) && !ref_q;
   endproperty
   a_cas_in_ras: assert property (p_cas_in_ras)
      else $error("column strobe outside a row cycle");
   property p_we_before_cas;
      @(posedge clk) disable iff (rst)
      $fell(dram_cas_n) && wr_q |-> $past(!dram_we_n, 1);
   endproperty
   a_we_before_cas: assert property (p_we_before_cas)
      else $error("write line not ahead of column strobe");
   property p_ref_row_only;
      @(posedge clk) disable iff (rst)
      gnt_ref |=> (ref_start && dram_ras_n == '0) [*5] ##1
         (dram_cas_n && dram_ras_n == '1);
   endproperty
   a_ref_row_only: assert property (p_ref_row_only)
      else $error("refresh cycle shape wrong");
   property p_slot_sel;
      @(posedge clk) disable iff (rst)
      (st_q == ST_ROW) && !ref_q |->
         dram_ras_n == ~(SLOTS'(1) << addr_q[17:15]);
   endproperty
   a_slot_sel: assert property (p_slot_sel)
      else $error("wrong slot strobed");
   property p_prio;
      @(posedge clk) disable iff (rst)
      idle && ref_pend_q |=> ref_q && !wr_q;
   endproperty
   a_prio: assert property (p_prio)
      else $error("refresh lost priority");
   property p_ar_hold;
      @(posedge clk) disable iff (rst)
      cpu_addr_rdy && cpu_req_f |=> cpu_addr_rdy;
   endproperty
   a_ar_hold: assert property (p_ar_hold)
      else $error("address ready dropped early");
   property p_store_ready;
      @(posedge clk) disable iff (rst)
      ar_set && wr_q |=> (own_dma_q ? (dma_data_rdy && dma_addr_rdy) :
         (cpu_data_rdy && cpu_addr_rdy));
   endproperty
   a_store_ready: assert property (p_store_ready)
      else $error("store data ready not with address ready");
   property p_row_inc;
      @(posedge clk) disable iff (rst)
      osc_tick |=> ref_pend_q && row_cnt_q == $past(row_cnt_q) + 1'b1;
   endproperty
   a_row_inc: assert property (p_row_inc)
      else $error("refresh request or row advance missing");
   property p_rd_push;
      @(posedge clk) disable iff (rst)
      rd_push |-> buf_in_ready ##1 rd_valid;
   endproperty
   a_rd_push: assert property (p_rd_push)
      else $error("read word not offered");
endmodule : lmi_top

// [sim/lmi_mem_model.sv]
// dram module array model on the memory bus side of the interface
`timescale 1ns/1ps
module lmi_mem_model import lmi_pkg::*; #(
   parameter logic [SLOTS-1:0] MASK21 = 8'h82
) (
   // strobes, address and store data from the interface
   input wire logic clk,
   input wire logic [SLOTS-1:0] dram_ras_n,
   input wire logic dram_cas_n,
   input wire logic dram_we_n,
   input wire logic dram_blk,
   input wire logic [ROW_W-1:0] dram_ma,
   input wire logic [MEM_W-1:0] dram_dq_out,
   // fault injection and module answers
   input wire logic flip,
   output logic [SLOTS-1:0] mod21,
   output logic [MEM_W-1:0] dram_dq_in,
   output logic [ADDR_W-1:0] last_addr
);
   logic [MEM_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [MEM_W-1:0] word_q = 21'h0;
   logic drv_q = 1'b0;
   logic cas_q = 1'b1;
   logic [SLOTS-1:0] ras_q = 8'hff;
   logic [2:0] slot_q = 3'h0;
   logic [ROW_W-1:0] row_q = 7'h0;
   wire [ADDR_W-1:0] key = {slot_q, dram_ma, row_q, dram_blk};
   assign mod21 = MASK21;
   // released bus shows the inverse, so a late capture cannot pass
   assign dram_dq_in = drv_q ? word_q ^ {20'h0, flip} : ~word_q;
   always @(posedge clk) begin
      ras_q <= dram_ras_n;
      cas_q <= dram_cas_n;
      if (ras_q == 8'hff && dram_ras_n != 8'hff) begin
         row_q <= dram_ma;
         for (int i = 0; i < SLOTS; i++)
            if (!dram_ras_n[i]) slot_q <= 3'(i);
      end
      if (cas_q && !dram_cas_n) begin
         last_addr <= key;
         if (!dram_we_n) mem[key] = dram_dq_out;
         else begin
            word_q <= mem.exists(key) ? mem[key] : 21'h0;
            drv_q <= 1'b1;
         end
      end
      if (dram_ras_n == 8'hff) drv_q <= 1'b0;
   end
endmodule : lmi_mem_model

// [sim/tb_top.sv]
// self-checking bench for the local memory interface
`timescale 1ns/1ps
module tb_top import lmi_pkg::*;;
   localparam int REF_N = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] req = 2'b00;
   logic [1:0] wr = 2'b00;
   logic [ADDR_W-1:0] addr [2] = '{default: '0};
   logic [DATA_W-1:0] wdat [2] = '{default: '0};
   logic [CODE_W-1:0] wr_code = '0;
   logic rd_ready = 1'b0;
   logic flip = 1'b0;
   wire [1:0] ardy;
   wire [1:0] drdy;
   logic rd_valid, rd_dma, rd_mod21, rd_par_err, reset_data;
   logic [DATA_W-1:0] rd_data;
   logic [CODE_W-1:0] rd_code;
   logic [SLOTS-1:0] mod21, dram_ras_n;
   logic dram_cas_n, dram_we_n, dram_blk, dram_dq_oe, mem_busy, ref_start;
   logic [ROW_W-1:0] dram_ma;
   logic [MEM_W-1:0] dram_dq_out, dram_dq_in;
   logic [ADDR_W-1:0] last_addr;
   int num_errors = 0;
   int check_count = 0;
   int n;

   lmi_top #(.REF_CYC(REF_N), .BUF_DEPTH(2)) DUT (
      .clk, .rst, .cpu_req(req[0]), .cpu_write(wr[0]),
      .cpu_addr(addr[0]), .cpu_wdata(wdat[0]), .cpu_addr_rdy(ardy[0]),
      .cpu_data_rdy(drdy[0]), .dma_req(req[1]), .dma_write(wr[1]),
      .dma_addr(addr[1]), .dma_wdata(wdat[1]), .dma_addr_rdy(ardy[1]),
      .dma_data_rdy(drdy[1]), .wr_code, .rd_valid, .rd_ready, .rd_data,
      .rd_code, .rd_dma, .rd_mod21, .rd_par_err, .reset_data, .mod21,
      .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_blk, .dram_ma,
      .dram_dq_out, .dram_dq_oe, .dram_dq_in, .mem_busy, .ref_start);
   lmi_mem_model #(.MASK21(8'h82)) u_mem (
      .clk, .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_blk, .dram_ma,
      .dram_dq_out, .flip, .mod21, .dram_dq_in, .last_addr);

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, exp, input string msg);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask : cyc

   // word as a module should hold it: code on 21-bit, odd parity else
   function automatic logic [20:0] expw(input logic m, input logic [15:0] d);
      if (m) return {d[4:0] ^ 5'h15, d};
      return {~^d[15:8], 3'h0, ~^d[7:0], d};
   endfunction : expw

   task automatic raise(input int s, input logic w, input logic [17:0] a,
         input logic [15:0] d);
      wr[s] = w;
      addr[s] = a;
      wdat[s] = d;
      if (w) wr_code = d[4:0] ^ 5'h15;
      req[s] = 1'b1;
   endtask : raise

   // hold the request until the address is taken, then drop it
   task automatic finish(input int s, input logic w);
      for (n = 0; n < 90 && ardy[s] !== 1'b1; n++) cyc(1);
      check(ardy[s], 1'b1, "address not taken");
      check(drdy[s], w, "data ready with address");
      check(dram_ras_n, 8'(~(8'h01 << addr[s][17:15])), "slot strobe");
      check(dram_dq_oe, w, "store data not driven");
      req[s] = 1'b0;
      for (n = 0; n < 12 && ardy[s] !== 1'b0; n++) cyc(1);
      check(ardy[s] | drdy[s], 1'b0, "ready did not drop");
   endtask : finish

   // f holds owner, 21-bit module and parity error flags
   task automatic take(input logic [20:0] w, input logic [2:0] f);
      for (n = 0; n < 40 && rd_valid !== 1'b1; n++) cyc(1);
      check(rd_data, w[15:0], "read data");
      check({rd_dma, rd_mod21, rd_par_err}, f, "read flags");
      if (f[1]) check(rd_code, w[20:16], "read code");
      rd_ready = 1'b1;
      #1;
      check(reset_data, 1'b1, "data not released");
      cyc(1);
      rd_ready = 1'b0;
      // one idle edge so a following take never re-raises ready at once
      cyc(1);
   endtask : take

   task automatic t_reset;
      check({dram_ras_n, dram_cas_n, dram_we_n}, 10'h3ff, "strobes");
      check({ardy, drdy, rd_valid, mem_busy, dram_dq_oe}, 7'h0, "idle");
   endtask : t_reset

   // store then load on alternate requesters, both module kinds
   task automatic t_rw;
      logic [17:0] a [4] = '{18'h0000b, 18'h0a5c3, 18'h3ffff, 18'h1d2a4};
      logic [15:0] d;
      logic m;
      for (int i = 0; i < 4; i++) begin
         d = 16'h9c35 ^ (16'h1111 * i);
         m = (a[i][17:15] == 3'h1) || (a[i][17:15] == 3'h7);
         raise(i % 2, 1'b1, a[i], d);
         finish(i % 2, 1'b1);
         cyc(4);
         check(last_addr, a[i], "store address");
         check(u_mem.mem[a[i]], expw(m, d), "stored word");
         raise(1 - i % 2, 1'b0, a[i], d);
         finish(1 - i % 2, 1'b0);
         take(expw(m, d), {i % 2 == 0, m, 1'b0});
      end
   endtask : t_rw

   // a bad bit from the module: parity flags it, code is left downstream
   task automatic t_parity;
      flip = 1'b1;
      raise(0, 1'b0, 18'h0000b, 16'h0);
      finish(0, 1'b0);
      take(expw(1'b0, 16'h9c35) ^ 21'h1, 3'b001);
      raise(1, 1'b0, 18'h0a5c3, 16'h0);
      finish(1, 1'b0);
      take(expw(1'b1, 16'h9c35 ^ 16'h1111) ^ 21'h1, 3'b110);
      flip = 1'b0;
   endtask : t_parity

   task automatic t_prio;
      raise(0, 1'b0, 18'h3ffff, 16'h0);
      raise(1, 1'b0, 18'h1d2a4, 16'h0);
      for (n = 0; n < 90 && ardy === 2'b00; n++) cyc(1);
      check(ardy, 2'b10, "dma served first");
      finish(1, 1'b0);
      finish(0, 1'b0);
      take(expw(1'b0, 16'h9c35 ^ 16'h3333), 3'b100);
      take(expw(1'b1, 16'h9c35 ^ 16'h2222), 3'b010);
   endtask : t_prio

   // reader stalls: two words fill the buffer, the third read must wait
   task automatic t_full;
      raise(0, 1'b0, 18'h0000b, 16'h0);
      finish(0, 1'b0);
      raise(1, 1'b0, 18'h0a5c3, 16'h0);
      finish(1, 1'b0);
      raise(0, 1'b0, 18'h3ffff, 16'h0);
      cyc(40);
      check({ardy[0], rd_valid}, 2'b01, "read over full buffer");
      take(expw(1'b0, 16'h9c35), 3'b000);
      finish(0, 1'b0);
      take(expw(1'b1, 16'h9c35 ^ 16'h1111), 3'b110);
      take(expw(1'b1, 16'h9c35 ^ 16'h2222), 3'b010);
   endtask : t_full

   task automatic t_refresh;
      logic [6:0] r;
      int p;
      // let a refresh delayed by earlier traffic pass before timing one
      cyc(50);
      for (n = 0; n < 20 && ref_start !== 1'b0; n++) cyc(1);
      for (n = 0; n < 200 && ref_start !== 1'b1; n++) cyc(1);
      check({dram_ras_n, dram_cas_n, mem_busy}, 10'h3, "refresh");
      r = dram_ma;
      for (n = 0; n < 20 && ref_start !== 1'b0; n++) cyc(1);
      for (p = n; p < 200 && ref_start !== 1'b1; p++) cyc(1);
      check(p, REF_N, "refresh period");
      check(dram_ma, 7'(r + 7'h1), "refresh row step");
   endtask : t_refresh

   initial begin
      #(25 * 8000);
      num_errors++;
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      #2;
      rst = 1'b0;
      t_reset();
      t_rw();
      t_parity();
      t_prio();
      t_full();
      t_refresh();
      finish_test();
   end
endmodule : tb_top
